//--- pms_pkg.sv
/*
  Package for the port MAC statistics and frame configuration block: register indices,
  field widths, reset values, timing counts and the frame event carriers.
  Assumes one 100 MHz clock and a 10 Mbit/s line.
*/
package pms_pkg;

  // Register indices, as the host addresses them.
  localparam logic [7:0] IDX_RX_LENGTH_ERROR_COUNT = 8'hA6;
  localparam logic [7:0] IDX_RX_PHY_ERROR_COUNT = 8'hA7;
  localparam logic [7:0] IDX_TX_TOTAL_FRAME_COUNT = 8'hA8;
  localparam logic [7:0] IDX_TX_BROADCAST_COUNT = 8'hA9;
  localparam logic [7:0] IDX_TX_MULTICAST_COUNT = 8'hAA;
  localparam logic [7:0] IDX_TX_UNICAST_COUNT = 8'hAB;
  localparam logic [7:0] IDX_RX_FIFO_FULL_DROP_COUNT = 8'hAC;
  localparam logic [7:0] IDX_RX_FILTER_DROP_COUNT = 8'hAD;
  localparam logic [7:0] IDX_RX_GAP_ERROR_COUNT = 8'hAE;
  localparam logic [7:0] IDX_TX_GAP_SETTING = 8'hB0;
  localparam logic [7:0] IDX_MAC_LOOPBACK_CONTROL = 8'hB3;
  localparam logic [7:0] IDX_RX_CRC_CHECK_CONTROL = 8'hB4;
  localparam logic [7:0] IDX_RX_GAP_SETTING = 8'hB5;
  localparam logic [7:0] IDX_RX_MAX_LENGTH = 8'hB6;
  localparam logic [7:0] IDX_RX_MIN_LENGTH = 8'hB7;
  localparam logic [7:0] IDX_LOW_PRIO_RX_FRAME_LEVEL = 8'hB8;

  // Statistics counters occupy consecutive indices from the first one.
  localparam int NUM_COUNTERS = 9;
  localparam int CNT_LENGTH_ERR = 0;
  localparam int CNT_PHY_ERR = 1;
  localparam int CNT_TX_TOTAL = 2;
  localparam int CNT_TX_BCAST = 3;
  localparam int CNT_TX_MCAST = 4;
  localparam int CNT_TX_UCAST = 5;
  localparam int CNT_FULL_DROP = 6;
  localparam int CNT_FILT_DROP = 7;
  localparam int CNT_GAP_ERR = 8;

  // Field widths and positions.
  localparam int TX_GAP_W = 8;
  localparam int RX_GAP_W = 6;
  localparam int LEN_W = 16;
  localparam int LEVEL_W = 9;
  localparam int LOOPBACK_BIT = 0;
  localparam int CRC_CHECK_BIT = 0;

  // Reset values.
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [7:0] TX_GAP_RESET = 8'h0B;
  localparam logic [5:0] RX_GAP_RESET = 6'h0A;
  localparam logic [15:0] RX_MAX_LEN_RESET = 16'h0618;
  localparam logic [15:0] RX_MIN_LEN_RESET = 16'h0040;
  localparam logic LOOPBACK_RESET = 1'b0;
  localparam logic CRC_CHECK_RESET = 1'b1;
  localparam logic [8:0] LEVEL_RESET = 9'h000;

  // Timing: bit time on the line and clock period, both in ns.
  localparam int BIT_TIME_NS = 100;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CYC_PER_BIT = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BITS_PER_GAP_UNIT = 8;
  localparam int GAP_CNT_W = 12;
  localparam int BIT_CYC_W = 4;

  typedef enum logic [1:0] {
    DST_UNICAST,
    DST_MULTICAST,
    DST_BROADCAST
  } pms_dst_t;

  typedef struct packed {
    logic valid;
    logic [15:0] length;
    logic phy_error;
  } pms_rx_end_t;

  typedef struct packed {
    logic valid;
    pms_dst_t dst;
  } pms_tx_end_t;

endpackage

//--- pms_port_mac_stats.sv
/*
  Port MAC statistics counters, read-only, and frame qualification settings, read and written by
  the host through a word register port at the printed indices.
  Assumes the frame events come from MAC logic on the same clock as one-cycle pulses.
*/
`timescale 1ns/1ps

// Notes on behaviour
// (R1) Count received frames breaking the length limits; 32 bits, read-only, reset zero.
// (R2) Count received frames that the PHY marked errored; 32 bits, reset zero.
// (R3) Count every transmitted frame; 32 bits, read-only, zero after reset.
// (R4) Separate transmit counters for broadcast, multicast and unicast destinations.
// (R5) Count received frames discarded because the receive FIFO was full.
// (R6) Count received frames discarded by address filtering.
// (R7) Count received frames preceded by a gap not longer than the receive setting.
// (R8) Transmit gap is (setting + 1) times 8 bit times; setting resets to eleven.
// (R9) Loopback bit 0 loops MII traffic back to the PHY; zero means normal.
// (R10) Receive CRC checking runs while its enable bit is set; set after reset.
// (R11) Received gap must exceed 6-bit setting times 8 bit times; resets to ten.
// (R12) On a short gap the following frame is discarded and gap error raised.
// (R13) Receive gap setting holds values up to 63.
// (R14) Maximum receive length is 16 bits read/write, resetting to 0x618 bytes.
// (R15) Minimum receive length is 16 bits read/write, resetting to 0x40 bytes.
// (R16) Low-priority receive FIFO frame level, 9 bits read-only, reset zero, debug.
// (R17) Host should poll frame-ready rather than the exact frame level.
// (R18) Receive statistics count good and errored frames alike.
// (R19) A length error is a length below minimum or above maximum.
module pms_port_mac_stats (
  // Clock, reset and clock enable.
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Host register port.
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_rd_valid_o,
  // Receive MAC events.
  input wire logic rx_active_i,
  input wire pms_pkg::pms_rx_end_t rx_end_i,
  input wire logic rx_drop_full_i,
  input wire logic rx_drop_filt_i,
  output logic rx_frame_discard_o,
  output logic rx_gap_error_flag_o,
  output logic rx_length_error_o,
  // Transmit MAC events.
  input wire logic tx_active_i,
  input wire pms_pkg::pms_tx_end_t tx_end_i,
  output logic tx_start_allow_o,
  // Low-priority receive FIFO frame tracking.
  input wire logic lo_frame_push_i,
  input wire logic lo_frame_pop_i,
  output logic rx_frame_ready_flag_o,
  // Configuration outputs to the MAC.
  output logic mac_loopback_enable_o,
  output logic rx_crc_check_enable_o
);

  typedef enum logic {
    PMS_RX_IDLE,
    PMS_RX_FRAME
  } pms_rx_state_t;

  logic [31:0] count_reg [pms_pkg::NUM_COUNTERS];
  logic [pms_pkg::NUM_COUNTERS-1:0] count_event;
  logic [7:0] tx_gap_setting_reg;
  logic [5:0] rx_gap_setting_reg;
  logic [15:0] rx_max_length_reg;
  logic [15:0] rx_min_length_reg;
  logic loopback_reg;
  logic crc_check_reg;
  logic [8:0] level_reg;
  logic [8:0] level_next;
  pms_rx_state_t rx_state_reg;
  logic [pms_pkg::BIT_CYC_W-1:0] rx_bit_cyc_reg;
  logic [pms_pkg::GAP_CNT_W-1:0] rx_gap_bits_reg;
  logic [pms_pkg::BIT_CYC_W-1:0] tx_bit_cyc_reg;
  logic [pms_pkg::GAP_CNT_W-1:0] tx_gap_bits_reg;
  logic [pms_pkg::GAP_CNT_W-1:0] rx_gap_limit;
  logic [pms_pkg::GAP_CNT_W-1:0] tx_gap_limit;
  logic rx_frame_start;
  logic rx_gap_short;
  logic rx_len_bad;
  logic tx_gap_met;
  logic [31:0] rdata_next;
  logic [7:0] cnt_index;

  localparam logic [pms_pkg::BIT_CYC_W-1:0] LAST_BIT_CYC =
    pms_pkg::BIT_CYC_W'(pms_pkg::CYC_PER_BIT - 1);
  localparam logic [pms_pkg::GAP_CNT_W-1:0] GAP_SAT = '1;
  localparam logic [pms_pkg::GAP_CNT_W-1:0] GAP_UNIT =
    pms_pkg::GAP_CNT_W'(pms_pkg::BITS_PER_GAP_UNIT);

  // Receive gap check and frame start detection.
  assign rx_gap_limit = pms_pkg::GAP_CNT_W'(rx_gap_setting_reg) * GAP_UNIT; // R11
  assign rx_frame_start = (rx_state_reg == PMS_RX_IDLE) && rx_active_i;
  assign rx_gap_short = rx_frame_start && (rx_gap_bits_reg <= rx_gap_limit); // R11

  // Length qualification at frame end; errored frames are checked as well.
  assign rx_len_bad = rx_end_i.valid && ((rx_end_i.length < rx_min_length_reg) ||
    (rx_end_i.length > rx_max_length_reg)); // R19

  // Transmit gap needed before the next frame.
  assign tx_gap_limit = (pms_pkg::GAP_CNT_W'(tx_gap_setting_reg) + 1'b1) * GAP_UNIT; // R8
  assign tx_gap_met = (tx_gap_bits_reg >= tx_gap_limit); // R8

  // Events that advance each statistics counter.
  always_comb begin
    count_event = '0;
    count_event[pms_pkg::CNT_LENGTH_ERR] = rx_len_bad; // R1
    count_event[pms_pkg::CNT_PHY_ERR] = rx_end_i.valid && rx_end_i.phy_error; // R2
    count_event[pms_pkg::CNT_TX_TOTAL] = tx_end_i.valid; // R3
    count_event[pms_pkg::CNT_TX_BCAST] = tx_end_i.valid &&
      (tx_end_i.dst == pms_pkg::DST_BROADCAST); // R4
    count_event[pms_pkg::CNT_TX_MCAST] = tx_end_i.valid &&
      (tx_end_i.dst == pms_pkg::DST_MULTICAST); // R4
    count_event[pms_pkg::CNT_TX_UCAST] = tx_end_i.valid &&
      (tx_end_i.dst == pms_pkg::DST_UNICAST); // R4
    count_event[pms_pkg::CNT_FULL_DROP] = rx_drop_full_i; // R5
    count_event[pms_pkg::CNT_FILT_DROP] = rx_drop_filt_i; // R6
    count_event[pms_pkg::CNT_GAP_ERR] = rx_gap_short; // R7
  end

  // Statistics counters; they wrap and cannot be written by the host.
  generate
    for (genvar i = 0; i < pms_pkg::NUM_COUNTERS; i++) begin : g_count
      logic [31:0] count_next;
      always_comb begin
        count_next = count_reg[i];
        if (count_event[i]) begin
          count_next = count_reg[i] + 32'h0000_0001; // R18
        end
      end
      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          count_reg[i] <= pms_pkg::COUNT_RESET; // R1
        end else if (ce_i) begin
          count_reg[i] <= count_next;
        end
      end
    end
  endgenerate

  // Configuration registers written by the host.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_gap_setting_reg <= pms_pkg::TX_GAP_RESET; // R8
    end else if (ce_i && reg_wr_i && (reg_addr_i == pms_pkg::IDX_TX_GAP_SETTING)) begin
      tx_gap_setting_reg <= reg_wdata_i[pms_pkg::TX_GAP_W-1:0]; // R8
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      loopback_reg <= pms_pkg::LOOPBACK_RESET; // R9
    end else if (ce_i && reg_wr_i && (reg_addr_i == pms_pkg::IDX_MAC_LOOPBACK_CONTROL)) begin
      loopback_reg <= reg_wdata_i[pms_pkg::LOOPBACK_BIT]; // R9
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      crc_check_reg <= pms_pkg::CRC_CHECK_RESET; // R10
    end else if (ce_i && reg_wr_i && (reg_addr_i == pms_pkg::IDX_RX_CRC_CHECK_CONTROL)) begin
      crc_check_reg <= reg_wdata_i[pms_pkg::CRC_CHECK_BIT]; // R10
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_gap_setting_reg <= pms_pkg::RX_GAP_RESET; // R11
    end else if (ce_i && reg_wr_i && (reg_addr_i == pms_pkg::IDX_RX_GAP_SETTING)) begin
      rx_gap_setting_reg <= reg_wdata_i[pms_pkg::RX_GAP_W-1:0]; // R13
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_max_length_reg <= pms_pkg::RX_MAX_LEN_RESET; // R14
    end else if (ce_i && reg_wr_i && (reg_addr_i == pms_pkg::IDX_RX_MAX_LENGTH)) begin
      rx_max_length_reg <= reg_wdata_i[pms_pkg::LEN_W-1:0]; // R14
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_min_length_reg <= pms_pkg::RX_MIN_LEN_RESET; // R15
    end else if (ce_i && reg_wr_i && (reg_addr_i == pms_pkg::IDX_RX_MIN_LENGTH)) begin
      rx_min_length_reg <= reg_wdata_i[pms_pkg::LEN_W-1:0]; // R15
    end
  end

  // Receive frame tracking and idle gap measurement in bit times.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_state_reg <= PMS_RX_IDLE;
      rx_bit_cyc_reg <= '0;
      rx_gap_bits_reg <= GAP_SAT;
    end else if (ce_i) begin
      case (rx_state_reg)
        PMS_RX_IDLE: begin
          if (rx_active_i) begin
            rx_state_reg <= PMS_RX_FRAME;
          end else if (rx_bit_cyc_reg == LAST_BIT_CYC) begin
            rx_bit_cyc_reg <= '0;
            if (rx_gap_bits_reg != GAP_SAT) begin
              rx_gap_bits_reg <= rx_gap_bits_reg + 1'b1; // R11
            end
          end else begin
            rx_bit_cyc_reg <= rx_bit_cyc_reg + 1'b1;
          end
        end
        PMS_RX_FRAME: begin
          rx_bit_cyc_reg <= '0;
          rx_gap_bits_reg <= '0;
          if (!rx_active_i) begin
            rx_state_reg <= PMS_RX_IDLE;
          end
        end
        default: begin
          rx_state_reg <= PMS_RX_IDLE;
        end
      endcase
    end
  end

  // Transmit idle gap measurement in bit times.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_bit_cyc_reg <= '0;
      tx_gap_bits_reg <= GAP_SAT;
    end else if (ce_i) begin
      if (tx_active_i) begin
        tx_bit_cyc_reg <= '0;
        tx_gap_bits_reg <= '0;
      end else if (tx_bit_cyc_reg == LAST_BIT_CYC) begin
        tx_bit_cyc_reg <= '0;
        if (tx_gap_bits_reg != GAP_SAT) begin
          tx_gap_bits_reg <= tx_gap_bits_reg + 1'b1; // R8
        end
      end else begin
        tx_bit_cyc_reg <= tx_bit_cyc_reg + 1'b1;
      end
    end
  end

  // Low-priority FIFO frame level; a push and pop together leave it unchanged.
  always_comb begin
    level_next = level_reg;
    if (lo_frame_push_i && !lo_frame_pop_i && (level_reg != '1)) begin
      level_next = level_reg + 1'b1;
    end else if (lo_frame_pop_i && !lo_frame_push_i && (level_reg != '0)) begin
      level_next = level_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      level_reg <= pms_pkg::LEVEL_RESET; // R16
    end else if (ce_i) begin
      level_reg <= level_next; // R16
    end
  end

  // Event indications to the receive MAC, registered.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_frame_discard_o <= 1'b0;
    end else if (ce_i) begin
      rx_frame_discard_o <= rx_gap_short; // R12
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_gap_error_flag_o <= 1'b0;
    end else if (ce_i) begin
      rx_gap_error_flag_o <= rx_gap_short; // R12
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_length_error_o <= 1'b0;
    end else if (ce_i) begin
      rx_length_error_o <= rx_len_bad; // R19
    end
  end

  // Register read multiplexer; unmapped indices and reserved bits read as zero.
  always_comb begin
    rdata_next = '0;
    cnt_index = reg_addr_i - pms_pkg::IDX_RX_LENGTH_ERROR_COUNT;
    if ((reg_addr_i >= pms_pkg::IDX_RX_LENGTH_ERROR_COUNT) &&
        (reg_addr_i <= pms_pkg::IDX_RX_GAP_ERROR_COUNT)) begin
      rdata_next = count_reg[cnt_index[3:0]];
    end else begin
      case (reg_addr_i)
        pms_pkg::IDX_TX_GAP_SETTING: begin
          rdata_next = {24'h00_0000, tx_gap_setting_reg};
        end
        pms_pkg::IDX_MAC_LOOPBACK_CONTROL: begin
          rdata_next = {31'h0000_0000, loopback_reg};
        end
        pms_pkg::IDX_RX_CRC_CHECK_CONTROL: begin
          rdata_next = {31'h0000_0000, crc_check_reg};
        end
        pms_pkg::IDX_RX_GAP_SETTING: begin
          rdata_next = {26'h000_0000, rx_gap_setting_reg};
        end
        pms_pkg::IDX_RX_MAX_LENGTH: begin
          rdata_next = {16'h0000, rx_max_length_reg};
        end
        pms_pkg::IDX_RX_MIN_LENGTH: begin
          rdata_next = {16'h0000, rx_min_length_reg};
        end
        pms_pkg::IDX_LOW_PRIO_RX_FRAME_LEVEL: begin
          rdata_next = {23'h00_0000, level_reg}; // R16
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rd_valid_o <= 1'b0;
    end else if (ce_i) begin
      reg_rd_valid_o <= reg_rd_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= '0;
    end else if (ce_i && reg_rd_i) begin
      reg_rdata_o <= rdata_next;
    end
  end

  // Configuration and status levels.
  assign tx_start_allow_o = !tx_active_i && tx_gap_met; // R8
  assign mac_loopback_enable_o = loopback_reg; // R9
  assign rx_crc_check_enable_o = crc_check_reg; // R10
  assign rx_frame_ready_flag_o = (level_reg != '0); // R17

endmodule // pms_port_mac_stats

//--- pms_port_mac_stats_assertions.sv
/*
  Concurrent checks on the port MAC statistics block ports.
  Assumes a bind to pms_port_mac_stats, one clock and a synchronous reset.
*/
`timescale 1ns/1ps
module pms_port_mac_stats_assertions (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Register port.
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic reg_rd_valid_o,
  // Frame events and settings.
  input wire pms_pkg::pms_rx_end_t rx_end_i,
  input wire logic rx_frame_discard_o,
  input wire logic rx_gap_error_flag_o,
  input wire logic rx_length_error_o,
  input wire logic tx_active_i,
  input wire logic tx_start_allow_o,
  input wire logic lo_frame_push_i,
  input wire logic lo_frame_pop_i,
  input wire logic rx_frame_ready_flag_o,
  input wire logic mac_loopback_enable_o,
  input wire logic rx_crc_check_enable_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_rd_valid_timing: assert property (ce_i |=> reg_rd_valid_o == $past(reg_rd_i))
    else $error("read valid does not follow the read strobe");
  chk_crc_reset_on: assert property ($fell(sys_rst_i) |-> rx_crc_check_enable_o)
    else $error("crc check not enabled after reset");
  chk_loop_reset_off: assert property ($fell(sys_rst_i) |-> !mac_loopback_enable_o)
    else $error("loopback not off after reset");
  chk_loop_write_bit: assert property (ce_i && reg_wr_i &&
    reg_addr_i == pms_pkg::IDX_MAC_LOOPBACK_CONTROL |=> mac_loopback_enable_o == $past(reg_wdata_i[0]))
    else $error("loopback output differs from written bit");
  chk_crc_write_bit: assert property (ce_i && reg_wr_i &&
    reg_addr_i == pms_pkg::IDX_RX_CRC_CHECK_CONTROL |=> rx_crc_check_enable_o == $past(reg_wdata_i[0]))
    else $error("crc check output differs from written bit");
  chk_discard_with_flag: assert property (rx_frame_discard_o |-> rx_gap_error_flag_o)
    else $error("discard without gap error flag");
  chk_tx_busy_block: assert property (tx_active_i |-> !tx_start_allow_o)
    else $error("start allowed while transmitting");
  chk_tx_gap_hold: assert property ($fell(tx_active_i) |-> (!tx_start_allow_o) [*8])
    else $error("start allowed before the minimum gap");
  chk_len_zero_error: assert property (ce_i && rx_end_i.valid &&
    rx_end_i.length == 16'h0000 |=> rx_length_error_o)
    else $error("zero length frame not flagged");
  chk_ready_after_push: assert property (ce_i && lo_frame_push_i && !lo_frame_pop_i
    |=> rx_frame_ready_flag_o)
    else $error("ready flag low after a frame was stored");

  cover property (rx_gap_error_flag_o);
  cover property (rx_length_error_o);
  cover property (reg_rd_valid_o && rx_frame_ready_flag_o);
endmodule // pms_port_mac_stats_assertions

//--- pms_host_model.sv
/*
  Host model that reaches the block's registers through its word port.
  Assumes the testbench calls its tasks; requests launch at falling edges.
*/
`timescale 1ns/1ps
module pms_host_model (
  // Clock.
  input wire logic clk_i,
  // Register port toward the block.
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [31:0] reg_wdata_o,
  output logic reg_rd_o,
  input wire logic [31:0] reg_rdata_i,
  input wire logic reg_rd_valid_i
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 32'h0000_0000;
    reg_rd_o = 1'b0;
  end
  // Released address and data lines are inverted, strobes cleared, so stale values never pass for live ones.
  task automatic release_bus();
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~reg_addr_o;
    reg_wdata_o = ~reg_wdata_o;
  endtask
  task automatic write_word(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    release_bus();
  endtask
  task automatic read_word(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    release_bus();
    d = reg_rd_valid_i ? reg_rdata_i : 32'hxxxx_xxxx;
  endtask
endmodule // pms_host_model

//--- pms_port_mac_stats_tb.sv
/*
  Self-checking testbench for the port MAC statistics block.
  Assumes the host model drives the register port and the bench drives frame events.
*/
`timescale 1ns/1ps
module pms_port_mac_stats_tb;
  logic clk_i, sys_rst_i, ce_i, rx_active_i, rx_drop_full_i, rx_drop_filt_i, tx_active_i;
  logic lo_frame_push_i, lo_frame_pop_i, reg_wr_i, reg_rd_i, reg_rd_valid_o;
  logic rx_frame_discard_o, rx_gap_error_flag_o, rx_length_error_o, tx_start_allow_o;
  logic rx_frame_ready_flag_o, mac_loopback_enable_o, rx_crc_check_enable_o;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, d;
  pms_pkg::pms_rx_end_t rx_end_i;
  pms_pkg::pms_tx_end_t tx_end_i;
  int bad_count = 0;
  int total_checks = 0;
  int gap_pulses = 0;

  pms_port_mac_stats i_pms_port_mac_stats (.clk_i, .sys_rst_i, .ce_i, .reg_addr_i, .reg_wr_i,
    .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rd_valid_o, .rx_active_i, .rx_end_i,
    .rx_drop_full_i, .rx_drop_filt_i, .rx_frame_discard_o, .rx_gap_error_flag_o,
    .rx_length_error_o, .tx_active_i, .tx_end_i, .tx_start_allow_o, .lo_frame_push_i,
    .lo_frame_pop_i, .rx_frame_ready_flag_o, .mac_loopback_enable_o, .rx_crc_check_enable_o);
  pms_host_model i_pms_host_model (.clk_i, .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
    .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o),
    .reg_rd_valid_i(reg_rd_valid_o));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(negedge clk_i)
    if (rx_gap_error_flag_o === 1'b1 && rx_frame_discard_o === 1'b1) gap_pulses++;

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    i_pms_host_model.read_word(a, d);
    chk(name, d, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    i_pms_host_model.write_word(a, v);
  endtask

  task automatic t_regs();
    logic [7:0] ra[6] = '{8'hB0, 8'hB3, 8'hB4, 8'hB5, 8'hB6, 8'hB7};
    logic [31:0] rv[6] = '{32'h0000_000B, 32'h0000_0000, 32'h0000_0001, 32'h0000_000A,
      32'h0000_0618, 32'h0000_0040};
    logic [31:0] rm[6] = '{32'h0000_00FF, 32'h0000_0001, 32'h0000_0001, 32'h0000_003F,
      32'h0000_FFFF, 32'h0000_FFFF};
    for (int i = 0; i < 10; i++) begin
      wr(8'hA6 + 8'(i), 32'hFFFF_FFFF);
      rd(8'hA6 + 8'(i), 32'h0000_0000, "counter or unmapped");
    end
    wr(8'hB8, 32'hFFFF_FFFF);
    rd(8'hB8, 32'h0000_0000, "frame level");
    foreach (ra[i]) begin
      rd(ra[i], rv[i], "reset value");
      wr(ra[i], 32'hFFFF_FFFF);
      rd(ra[i], rm[i], "field width");
      wr(ra[i], rv[i]);
    end
    wr(pms_pkg::IDX_MAC_LOOPBACK_CONTROL, 32'h0000_0001);
    wr(pms_pkg::IDX_RX_CRC_CHECK_CONTROL, 32'h0000_0000);
    chk("loopback out", 32'(mac_loopback_enable_o), 32'h0000_0001);
    chk("crc check out", 32'(rx_crc_check_enable_o), 32'h0000_0000);
    wr(pms_pkg::IDX_MAC_LOOPBACK_CONTROL, 32'h0000_0000);
    wr(pms_pkg::IDX_RX_CRC_CHECK_CONTROL, 32'h0000_0001);
    $display("t_regs done");
  endtask

  task automatic t_rx_gap();
    wr(pms_pkg::IDX_RX_GAP_SETTING, 32'h0000_0002);
    gap_pulses = 0;
    for (int i = 0; i < 3; i++) begin
      @(negedge clk_i);
      rx_active_i = 1'b1;
      repeat (20) @(negedge clk_i);
      rx_active_i = 1'b0;
      repeat (i == 1 ? 150 : 200) @(negedge clk_i);
    end
    chk("gap error pulses", 32'(gap_pulses), 32'h0000_0001);
    rd(pms_pkg::IDX_RX_GAP_ERROR_COUNT, 32'h0000_0001, "gap error count");
    $display("t_rx_gap done");
  endtask

  task automatic t_rx_counts();
    @(negedge clk_i);
    rx_end_i = '{1'b1, 16'h0000, 1'b1};
    @(negedge clk_i);
    chk("short length pulse", 32'(rx_length_error_o), 32'h0000_0001);
    rx_end_i = '{1'b1, 16'h0619, 1'b0};
    @(negedge clk_i);
    chk("long length pulse", 32'(rx_length_error_o), 32'h0000_0001);
    rx_end_i = '{1'b1, 16'h0618, 1'b0};
    rx_drop_full_i = 1'b1;
    @(negedge clk_i);
    chk("max length no pulse", 32'(rx_length_error_o), 32'h0000_0000);
    rx_end_i = '{1'b1, 16'h0040, 1'b1};
    rx_drop_full_i = 1'b0;
    rx_drop_filt_i = 1'b1;
    @(negedge clk_i);
    rx_end_i.valid = 1'b0;
    rx_drop_filt_i = 1'b0;
    rd(pms_pkg::IDX_RX_LENGTH_ERROR_COUNT, 32'h0000_0002, "length errors");
    rd(pms_pkg::IDX_RX_PHY_ERROR_COUNT, 32'h0000_0002, "phy errors");
    rd(pms_pkg::IDX_RX_FIFO_FULL_DROP_COUNT, 32'h0000_0001, "full drops");
    rd(pms_pkg::IDX_RX_FILTER_DROP_COUNT, 32'h0000_0001, "filter drops");
    $display("t_rx_counts done");
  endtask

  task automatic t_tx_counts();
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i);
      tx_end_i = '{1'b1, pms_pkg::pms_dst_t'(i)};
    end
    @(negedge clk_i);
    ce_i = 1'b0;
    @(negedge clk_i);
    tx_end_i.valid = 1'b0;
    ce_i = 1'b1;
    rd(pms_pkg::IDX_TX_TOTAL_FRAME_COUNT, 32'h0000_0004, "tx total");
    rd(pms_pkg::IDX_TX_BROADCAST_COUNT, 32'h0000_0001, "tx broadcast");
    rd(pms_pkg::IDX_TX_MULTICAST_COUNT, 32'h0000_0001, "tx multicast");
    rd(pms_pkg::IDX_TX_UNICAST_COUNT, 32'h0000_0001, "tx unicast");
    $display("t_tx_counts done");
  endtask

  task automatic t_tx_gap();
    int n;
    wr(pms_pkg::IDX_TX_GAP_SETTING, 32'h0000_0001);
    chk("idle start allow", 32'(tx_start_allow_o), 32'h0000_0001);
    @(negedge clk_i);
    tx_active_i = 1'b1;
    repeat (30) @(negedge clk_i);
    tx_active_i = 1'b0;
    n = 0;
    while (tx_start_allow_o !== 1'b1 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    chk("tx gap near 160 cycles", 32'(n >= 155 && n <= 170), 32'h0000_0001);
    $display("t_tx_gap done");
  endtask

  task automatic t_level();
    @(negedge clk_i);
    lo_frame_push_i = 1'b1;
    repeat (3) @(negedge clk_i);
    lo_frame_pop_i = 1'b1;
    @(negedge clk_i);
    lo_frame_push_i = 1'b0;
    @(negedge clk_i);
    lo_frame_pop_i = 1'b0;
    rd(pms_pkg::IDX_LOW_PRIO_RX_FRAME_LEVEL, 32'h0000_0002, "frame level");
    chk("ready flag set", 32'(rx_frame_ready_flag_o), 32'h0000_0001);
    lo_frame_pop_i = 1'b1;
    repeat (3) @(negedge clk_i);
    lo_frame_pop_i = 1'b0;
    rd(pms_pkg::IDX_LOW_PRIO_RX_FRAME_LEVEL, 32'h0000_0000, "drained level");
    chk("ready flag clear", 32'(rx_frame_ready_flag_o), 32'h0000_0000);
    $display("t_level done");
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    {sys_rst_i, ce_i} = 2'b11;
    {rx_active_i, rx_drop_full_i, rx_drop_filt_i, tx_active_i} = 4'h0;
    {lo_frame_push_i, lo_frame_pop_i} = 2'b00;
    rx_end_i = '{1'b0, 16'h0000, 1'b0};
    tx_end_i = '{1'b0, pms_pkg::DST_UNICAST};
    repeat (4) @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_regs();
    t_rx_gap();
    t_rx_counts();
    t_tx_counts();
    t_tx_gap();
    t_level();
    wrap_up();
  end
  initial begin
    #300_000;
    bad_count++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule // pms_port_mac_stats_tb

bind pms_port_mac_stats pms_port_mac_stats_assertions i_pms_port_mac_stats_assertions (.clk_i,
  .sys_rst_i, .ce_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rd_valid_o,
  .rx_end_i, .rx_frame_discard_o, .rx_gap_error_flag_o, .rx_length_error_o, .tx_active_i,
  .tx_start_allow_o, .lo_frame_push_i, .lo_frame_pop_i, .rx_frame_ready_flag_o,
  .mac_loopback_enable_o, .rx_crc_check_enable_o);
